//--- hw/gpw_defs.vh
`ifndef GPW_DEFS_VH
`define GPW_DEFS_VH

// logical unit numbers selected on the configuration port
`define GPW_LU_PORT6          8'h07
`define GPW_LU_GPIO           8'h09
`define GPW_LU_ACPI           8'h0A

// per-port register block: base + 4*port + field, port six at base + field
`define GPW_PORT_BASE         8'hD0
`define GPW_FLD_SEL           2'h0
`define GPW_FLD_DATA          2'h1
`define GPW_FLD_INV           2'h2
`define GPW_FLD_ALT           2'h3

// wake event registers
`define GPW_OFS_WAKE_STATUS   8'hE7
`define GPW_OFS_WAKE_POL      8'hF2
`define GPW_OFS_WAKE_DBTYPE   8'hFE
`define GPW_OFS_WAKE_ROUTE    8'hFE

// reset values
`define GPW_RST_SEL           8'hFF
`define GPW_RST_DATA          8'h00
`define GPW_RST_INV           8'h00
`define GPW_RST_ALT           8'h00
`define GPW_RST_WAKE          8'h00

// wake pins sit on port 3 (port index 1), bits 0, 1 and 5
`define GPW_WAKE_PORT         3'h1
`define GPW_WAKE_BIT0         3'h0
`define GPW_WAKE_BIT1         3'h1
`define GPW_WAKE_BIT2         3'h5

// watchdog alternate on port 4 (port index 2)
`define GPW_WDT_PORT          3'h2
`define GPW_WDT_OD_MASK       8'h51
`define GPW_WDT_PP_MASK       8'h04

// debounce time
`define GPW_CLK_HZ            50000000
`define GPW_DEBOUNCE_MS       16
`define GPW_DEBOUNCE_CYC      ((`GPW_CLK_HZ / 1000) * `GPW_DEBOUNCE_MS)

`endif

//--- hw/gpw_debounce.v
`include "gpw_defs.vh"

// holds its output until the input has been stable for the full count
module gpw_debounce #(
    parameter integer COUNT = `GPW_DEBOUNCE_CYC
) (
    input  wire mclk,
    input  wire rst,
    input  wire din,
    output reg  dout
);
    reg [19:0] cnt_q;   // cycles the input has differed from dout

    // restart on any bounce, commit after COUNT steady cycles
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 20'h00000;
            dout  <= 1'b0;
        end else if (din == dout) begin
            cnt_q <= 20'h00000;
        end else if (cnt_q >= COUNT[19:0] - 20'h00001) begin
            cnt_q <= 20'h00000;
            dout  <= din;
        end else begin
            cnt_q <= cnt_q + 20'h00001;
        end
    end
endmodule // gpw_debounce

//--- hw/gpw_top.v
// Functional notes
// - forty pins, each plain I/O or alternate
// - per-pin direction bit, 0 output, 1 input
// - per-pin inversion bit between pin and data
// - data register reads pin, writes drive value
// - port six in one unit, two-five another
// - only three wake pins raise wake requests
// - per-pin routes to wake and event outputs
// - wake inputs debounced about sixteen milliseconds
// - debounce bypass bits four to six
// - type bit: zero edge, one level
// - polarity bit: zero rising, one falling
// - four port-four pins may output watchdog timeout
`include "gpw_defs.vh"

module gpw_top #(
    parameter integer DEBOUNCE_CYC = `GPW_DEBOUNCE_CYC
) (
    input  wire        mclk,
    input  wire        rst,
    // configuration port: unit and index select a register, strobes act at
    // the rising edge on which they are high, one access per strobe
    input  wire [7:0]  cfg_unit,
    input  wire [7:0]  cfg_index,
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:0]  cfg_wdata,
    output reg  [7:0]  cfg_rdata,
    output reg         cfg_rvalid,
    // pin side: bit 8*i+b is port (i+2) bit b, the last byte is port six
    input  wire [39:0] gpio_in,
    output wire [39:0] gpio_out,
    output wire [39:0] gpio_oe,
    output wire [39:0] gpio_alt_sel,
    input  wire [39:0] alt_out_i,
    input  wire [39:0] alt_oe_i,
    // timeout from the watchdog and the two active-low wake routes
    input  wire        watchdog_timeout_out_n,
    output reg         power_button_wake_out_n,
    output reg         pme_out_n
);
    // decode of one per-port register; port 4 is the port-six block
    // ports two to five share one unit and sit four indexes apart,
    // port six lives in its own unit and starts again at the base index
    // used by both the write path and the read multiplexer, so the map
    // is kept in one place and cannot drift between them
    function port_hit;
        input [7:0] unit;
        input [7:0] index;
        input [2:0] port;
        input [1:0] fld;
        reg   [7:0] ofs;
        begin
            ofs = (port == 3'h4) ? `GPW_PORT_BASE : (`GPW_PORT_BASE + {3'h0, port, 2'h0});
            ofs = ofs + {6'h00, fld};
            port_hit = (index == ofs) &&
                       (unit == ((port == 3'h4) ? `GPW_LU_PORT6 : `GPW_LU_GPIO));
        end
    endfunction

    // decode of a single-unit register
    // the wake registers have no per-port copies, so a plain compare of
    // unit and index is enough; note that index FE exists in two units
    function reg_hit;
        input [7:0] unit;
        input [7:0] index;
        input [7:0] want_unit;
        input [7:0] want_ofs;
        begin
            reg_hit = (unit == want_unit) && (index == want_ofs);
        end
    endfunction

    // pin configuration, one bit per pin, five bytes wide
    // all pins come out of reset as inputs, so nothing is driven until
    // software has chosen a direction or an alternate function
    reg  [39:0] sel_q;            // direction, 1 = input
    reg  [39:0] dat_q;            // data written by software
    reg  [39:0] inv_q;            // inversion per pin
    reg  [39:0] alt_q;            // alternate function select
    reg  [39:0] out_q;            // registered pin drive
    reg  [39:0] oe_q;             // registered pin enable
    wire [39:0] pin_val;          // pin value seen through inversion

    // pin outputs straight from flip-flops, no logic after the register
    assign gpio_out     = out_q;
    assign gpio_oe      = oe_q;
    assign gpio_alt_sel = alt_q;
    assign pin_val      = gpio_in ^ inv_q;

    // per-port configuration and pin drive
    genvar p;
    generate
        for (p = 0; p < 5; p = p + 1) begin : g_port
            localparam [2:0] PIDX = p; // port index at decoder width
            wire [7:0] wdt_od;     // open-drain watchdog pins of this port
            wire [7:0] wdt_pp;     // push-pull watchdog pins of this port
            wire [7:0] drv;        // inverted data toward the pin
            assign wdt_od = (p == `GPW_WDT_PORT) ? `GPW_WDT_OD_MASK : 8'h00;
            assign wdt_pp = (p == `GPW_WDT_PORT) ? `GPW_WDT_PP_MASK : 8'h00;
            assign drv    = dat_q[p*8 +: 8] ^ inv_q[p*8 +: 8];

            // configuration writes
            // data is stored pre-inverted so that the pin shows the written
            // value; changing the inversion later flips the pin, by intent
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    sel_q[p*8 +: 8] <= `GPW_RST_SEL;
                    dat_q[p*8 +: 8] <= `GPW_RST_DATA;
                    inv_q[p*8 +: 8] <= `GPW_RST_INV;
                    alt_q[p*8 +: 8] <= `GPW_RST_ALT;
                end else if (cfg_wr) begin
                    if (port_hit(cfg_unit, cfg_index, PIDX, `GPW_FLD_SEL))
                        sel_q[p*8 +: 8] <= cfg_wdata;
                    if (port_hit(cfg_unit, cfg_index, PIDX, `GPW_FLD_DATA))
                        dat_q[p*8 +: 8] <= cfg_wdata ^ inv_q[p*8 +: 8];
                    if (port_hit(cfg_unit, cfg_index, PIDX, `GPW_FLD_INV))
                        inv_q[p*8 +: 8] <= cfg_wdata;
                    if (port_hit(cfg_unit, cfg_index, PIDX, `GPW_FLD_ALT))
                        alt_q[p*8 +: 8] <= cfg_wdata;
                end
            end

            // pin drive: alternate first, then plain output, else float
            // watchdog pins ignore the alternate inputs from other blocks:
            // open-drain ones only ever pull low, push-pull ones always
            // drive the timeout level; every other alternate pin simply
            // passes the drive and enable of the block that owns it
            // one cycle of latency from any change to the pin
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    out_q[p*8 +: 8] <= 8'h00;
                    oe_q[p*8 +: 8]  <= 8'h00;
                end else begin
                    out_q[p*8 +: 8] <= (alt_q[p*8 +: 8] & wdt_pp &
                                        {8{watchdog_timeout_out_n}}) |
                                       (alt_q[p*8 +: 8] & ~wdt_od & ~wdt_pp &
                                        alt_out_i[p*8 +: 8]) |
                                       (~alt_q[p*8 +: 8] & drv);
                    oe_q[p*8 +: 8]  <= (alt_q[p*8 +: 8] & wdt_pp) |
                                       (alt_q[p*8 +: 8] & wdt_od &
                                        {8{~watchdog_timeout_out_n}}) |
                                       (alt_q[p*8 +: 8] & ~wdt_od & ~wdt_pp &
                                        alt_oe_i[p*8 +: 8]) |
                                       (~alt_q[p*8 +: 8] & ~sel_q[p*8 +: 8]);
                end
            end
        end
    endgenerate

    // wake event configuration
    // three wake pins only, index 0..2 = port three bits 0, 1 and 5
    // bit 2 of each field sits at register bit 5 in status and polarity,
    // but at bit 2 / bit 6 in the type, bypass and route registers
    reg  [2:0] db_off_q;          // debounce bypass per wake pin
    reg  [2:0] type_q;            // 0 edge, 1 level
    reg  [2:0] pol_q;             // 0 rising, 1 falling
    reg  [2:0] rt_wake_q;         // route to power-button wake
    reg  [2:0] rt_pme_q;          // route to event line
    reg  [2:0] stat_q;            // sticky event status
    reg  [2:0] act_q;             // previous active level, for edges
    wire [2:0] raw;               // wake pin levels
    wire [2:0] filt;              // debounced levels
    wire [2:0] used;              // level after optional debounce
    wire [2:0] act;               // level after polarity
    wire [2:0] hit;               // qualified event this cycle
    wire [2:0] clr;               // software clear strobe

    // pick the wake pins out of the pin bus; no other pin reaches the
    // event logic, whatever its configuration
    assign raw = {gpio_in[`GPW_WAKE_PORT*8 + `GPW_WAKE_BIT2],
                  gpio_in[`GPW_WAKE_PORT*8 + `GPW_WAKE_BIT1],
                  gpio_in[`GPW_WAKE_PORT*8 + `GPW_WAKE_BIT0]};

    // per wake pin: filter, bypass mux, polarity and edge/level qualify
    // the filter always runs, so turning the bypass off later switches
    // to a filtered level that is already settled; the switch itself may
    // still look like an edge if raw and filtered levels differ then
    // the edge history is taken after polarity, so a polarity change can
    // itself produce an edge toward the active level
    genvar w;
    generate
        for (w = 0; w < 3; w = w + 1) begin : g_wake
            gpw_debounce #(
                .COUNT (DEBOUNCE_CYC)
            ) u_db (
                .mclk (mclk),
                .rst  (rst),
                .din  (raw[w]),
                .dout (filt[w])
            );
            assign used[w] = db_off_q[w] ? raw[w] : filt[w];
            assign act[w]  = used[w] ^ pol_q[w];
            assign hit[w]  = type_q[w] ? act[w] : (act[w] & ~act_q[w]);
        end
    endgenerate

    // write-one-to-clear strobe for the status bits
    assign clr = (cfg_wr && reg_hit(cfg_unit, cfg_index, `GPW_LU_GPIO,
                  `GPW_OFS_WAKE_STATUS)) ? {cfg_wdata[5], cfg_wdata[1:0]} : 3'h0;

    // wake configuration writes, status set wins over clear
    // an event landing on the clear cycle is never lost; in level mode
    // the bit therefore comes straight back while the level is active
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            db_off_q  <= 3'h0;
            type_q    <= 3'h0;
            pol_q     <= 3'h0;
            rt_wake_q <= 3'h0;
            rt_pme_q  <= 3'h0;
            stat_q    <= 3'h0;
            act_q     <= 3'h0;
        end else begin
            act_q  <= act;
            stat_q <= (stat_q & ~clr) | hit;
            if (cfg_wr && reg_hit(cfg_unit, cfg_index, `GPW_LU_GPIO, `GPW_OFS_WAKE_DBTYPE)) begin
                db_off_q <= cfg_wdata[6:4];
                type_q   <= cfg_wdata[2:0];
            end
            if (cfg_wr && reg_hit(cfg_unit, cfg_index, `GPW_LU_GPIO, `GPW_OFS_WAKE_POL))
                pol_q <= {cfg_wdata[5], cfg_wdata[1:0]};
            if (cfg_wr && reg_hit(cfg_unit, cfg_index, `GPW_LU_ACPI, `GPW_OFS_WAKE_ROUTE)) begin
                rt_wake_q <= cfg_wdata[6:4];
                rt_pme_q  <= cfg_wdata[2:0];
            end
        end
    end

    // route outputs, active low
    // each output is low while any status bit with its route enabled is
    // set; clearing the status or the route releases it one cycle later
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            power_button_wake_out_n <= 1'b1;
            pme_out_n               <= 1'b1;
        end else begin
            power_button_wake_out_n <= ~|(stat_q & rt_wake_q);
            pme_out_n               <= ~|(stat_q & rt_pme_q);
        end
    end

    // read multiplexer
    // unmapped unit or index reads as zero; the data field returns the
    // pin level through the inversion, not the stored drive value
    // wake bits are placed back at their register positions
    reg [7:0] rd_d;
    integer   k;
    always @* begin
        rd_d = 8'h00;
        for (k = 0; k < 5; k = k + 1) begin
            if (port_hit(cfg_unit, cfg_index, k[2:0], `GPW_FLD_SEL))
                rd_d = sel_q[k*8 +: 8];
            if (port_hit(cfg_unit, cfg_index, k[2:0], `GPW_FLD_DATA))
                rd_d = pin_val[k*8 +: 8];
            if (port_hit(cfg_unit, cfg_index, k[2:0], `GPW_FLD_INV))
                rd_d = inv_q[k*8 +: 8];
            if (port_hit(cfg_unit, cfg_index, k[2:0], `GPW_FLD_ALT))
                rd_d = alt_q[k*8 +: 8];
        end
        if (reg_hit(cfg_unit, cfg_index, `GPW_LU_GPIO, `GPW_OFS_WAKE_STATUS))
            rd_d = {2'h0, stat_q[2], 3'h0, stat_q[1:0]};
        if (reg_hit(cfg_unit, cfg_index, `GPW_LU_GPIO, `GPW_OFS_WAKE_POL))
            rd_d = {2'h0, pol_q[2], 3'h0, pol_q[1:0]};
        if (reg_hit(cfg_unit, cfg_index, `GPW_LU_GPIO, `GPW_OFS_WAKE_DBTYPE))
            rd_d = {1'b0, db_off_q, 1'b0, type_q};
        if (reg_hit(cfg_unit, cfg_index, `GPW_LU_ACPI, `GPW_OFS_WAKE_ROUTE))
            rd_d = {1'b0, rt_wake_q, 1'b0, rt_pme_q};
    end

    // read data registered one cycle after the strobe
    // data holds until the next read so a slow master may take it late;
    // the valid flag is a single-cycle pulse
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_rdata  <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd)
                cfg_rdata <= rd_d;
        end
    end
endmodule // gpw_top

//--- verification/gpw_board.sv
// board side of the pins: design drives where enabled, board elsewhere
module gpw_board (
    input  wire [39:0] drv_out,
    input  wire [39:0] drv_oe,
    input  wire [39:0] brd,
    output wire [39:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // resolve each wire from the design's enable alone; the board drives wherever it is off
    assign pins = (drv_oe & drv_out) | (~drv_oe & brd);
endmodule // gpw_board

//--- verification/gpw_top_properties.sv
// port-level checks of the gpio and wake block
module gpw_top_properties #(
    parameter integer DEBOUNCE_CYC = 8
) (
    input wire        mclk,
    input wire        rst,
    input wire [7:0]  cfg_unit,
    input wire        cfg_rd,
    input wire [7:0]  cfg_rdata,
    input wire        cfg_rvalid,
    input wire [39:0] gpio_out,
    input wire [39:0] gpio_oe,
    input wire [39:0] gpio_alt_sel,
    input wire [39:0] alt_out_i,
    input wire [39:0] alt_oe_i,
    input wire        watchdog_timeout_out_n,
    input wire        power_button_wake_out_n,
    input wire        pme_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // read request and its one-cycle answer
    sequence s_rd; cfg_rd; endsequence
    sequence s_ans; cfg_rvalid; endsequence
    chk_rd_answer: assert property (s_rd |=> s_ans)
        else $error("read got no answer");
    chk_rv_cause: assert property (cfg_rvalid |-> $past(cfg_rd))
        else $error("answer without read");
    chk_rdata_hold: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
        else $error("read data moved");
    chk_unmapped_rd: assert property (cfg_rd && cfg_unit == 8'h00 |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_alt_pass: assert property (gpio_alt_sel[0] |=> gpio_out[0] == $past(alt_out_i[0])
        && gpio_oe[0] == $past(alt_oe_i[0]))
        else $error("alternate drive wrong");
    chk_wdt_od: assert property (gpio_alt_sel[16] |=> !gpio_out[16]
        && gpio_oe[16] == !$past(watchdog_timeout_out_n))
        else $error("open-drain timeout wrong");
    chk_wdt_pp: assert property (gpio_alt_sel[18] |=> gpio_oe[18]
        && gpio_out[18] == $past(watchdog_timeout_out_n))
        else $error("push-pull timeout wrong");
    chk_reset_idle: assert property (disable iff (1'b0) rst |-> gpio_oe == 40'h0
        && power_button_wake_out_n && pme_out_n)
        else $error("outputs active in reset");
endmodule // gpw_top_properties

bind gpw_top gpw_top_properties #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) gpw_top_properties_inst (
    .mclk, .rst, .cfg_unit, .cfg_rd, .cfg_rdata, .cfg_rvalid, .gpio_out, .gpio_oe,
    .gpio_alt_sel, .alt_out_i, .alt_oe_i, .watchdog_timeout_out_n,
    .power_button_wake_out_n, .pme_out_n);

//--- verification/gpio_ports_with_wake_events_bench.sv
module gpio_ports_with_wake_events_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0, rst = 0, cfg_wr = 0, cfg_rd = 0, wdt_n = 1;
    logic [7:0]  cfg_unit = 8'h00, cfg_index = 8'h00, cfg_wdata = 8'h00;
    logic [39:0] brd = 40'h0, alt_v = 40'hFF_FFFF_FFFF;
    wire  [7:0]  cfg_rdata;
    wire         cfg_rvalid, pbw_n, pme_n;
    wire  [39:0] pins, gout, goe;
    int          error_cnt = 0, cmp_count = 0;
    always #10 mclk = ~mclk; // 50 MHz
    gpw_top #(.DEBOUNCE_CYC(8)) gpw_top_inst (.mclk(mclk), .rst(rst), .cfg_unit(cfg_unit),
        .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .gpio_in(pins), .gpio_out(gout),
        .gpio_oe(goe), .gpio_alt_sel(), .alt_out_i(alt_v), .alt_oe_i(alt_v),
        .watchdog_timeout_out_n(wdt_n), .power_button_wake_out_n(pbw_n), .pme_out_n(pme_n));
    gpw_board gpw_board_inst (.drv_out(gout), .drv_oe(goe), .brd(brd), .pins(pins));
    task automatic finish_test;
        $display("compares=%0d errors=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // compare and report
    task automatic ck(input logic [39:0] s, input logic [39:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] u, i, d);
        @(posedge mclk);
        {cfg_unit, cfg_index, cfg_wdata, cfg_wr} <= {u, i, d, 1'b1};
        @(posedge mclk);
        cfg_wr <= 1'b0;
    endtask
    // one-cycle read strobe, answer one cycle later, masked compare
    task automatic rd(input logic [7:0] u, i, e, m);
        @(posedge mclk);
        {cfg_unit, cfg_index, cfg_rd} <= {u, i, 1'b1};
        @(posedge mclk);
        cfg_rd <= 1'b0;
        #1;
        ck({cfg_rvalid, cfg_rdata & m}, {1'b1, e & m});
    endtask
    task automatic t_regs;
        ck(goe, 40'h0);
        rd(8'h09, 8'hD0, 8'hFF, 8'hFF);
        rd(8'h07, 8'hD0, 8'hFF, 8'hFF);
        rd(8'h00, 8'hD0, 8'h00, 8'hFF);
        rd(8'h09, 8'hE7, 8'h00, 8'hFF);
    endtask
    task automatic t_pins;
        wr(8'h09, 8'hD0, 8'h00);
        wr(8'h09, 8'hD1, 8'hA5);
        wt(2);
        ck({goe[7:0], gout[7:0]}, 16'hFFA5);
        wr(8'h09, 8'hD2, 8'h0F);
        wt(2);
        ck(gout[7:0], 8'hAA);
        rd(8'h09, 8'hD1, 8'hA5, 8'hFF);
        wr(8'h07, 8'hD0, 8'hF0);
        wr(8'h07, 8'hD1, 8'h3C);
        wt(2);
        ck({goe[39:32], gout[39:32]}, 16'h0F3C);
        rd(8'h07, 8'hD1, 8'h0C, 8'hFF);
    endtask
    // bypassed filter: edge, falling, level and route choice
    task automatic t_wake;
        wr(8'h09, 8'hFE, 8'h70);
        wr(8'h0A, 8'hFE, 8'h11);
        brd[8] <= 1'b1;
        wt(3);
        ck({pbw_n, pme_n}, 2'b00);
        rd(8'h09, 8'hE7, 8'h01, 8'hFF);
        wr(8'h09, 8'hE7, 8'h01);
        wt(2);
        ck({pbw_n, pme_n}, 2'b11);
        wr(8'h09, 8'hF2, 8'h01);
        wr(8'h09, 8'hE7, 8'hFF);
        brd[8] <= 1'b0;
        wt(3);
        rd(8'h09, 8'hE7, 8'h01, 8'hFF);
        wr(8'h09, 8'hFE, 8'h71);
        wr(8'h09, 8'hE7, 8'h01);
        rd(8'h09, 8'hE7, 8'h01, 8'hFF);
        wr(8'h09, 8'hF2, 8'h00);
        wr(8'h09, 8'hE7, 8'hFF);
        rd(8'h09, 8'hE7, 8'h00, 8'hFF);
        wr(8'h0A, 8'hFE, 8'h40);
        wr(8'h09, 8'hFE, 8'h70);
        brd[13] <= 1'b1;
        wt(3);
        ck({pbw_n, pme_n}, 2'b01);
    endtask
    // filter active: no event before the count runs out
    task automatic t_debounce;
        wr(8'h09, 8'hFE, 8'h00);
        wr(8'h09, 8'hE7, 8'hFF);
        brd[9] <= 1'b1;
        wt(4);
        rd(8'h09, 8'hE7, 8'h00, 8'h02);
        wt(12);
        rd(8'h09, 8'hE7, 8'h02, 8'h02);
    endtask
    // timeout alternate on port four, plain alternate on port two
    task automatic t_alt;
        wr(8'h09, 8'hDB, 8'h05);
        wdt_n <= 1'b0;
        wt(2);
        ck({goe[18], gout[18], goe[16], gout[16]}, 4'hA);
        @(posedge mclk);
        wdt_n <= 1'b1;
        wt(2);
        ck({goe[18], gout[18], goe[16], gout[16]}, 4'hC);
        wr(8'h09, 8'hD3, 8'h01);
        wt(2);
        ck({goe[0], gout[0]}, 2'b11);
    endtask
    // hang limit
    initial begin
        #1000000;
        error_cnt++;
        finish_test();
    end
    initial begin
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_pins();
        t_wake();
        t_debounce();
        t_alt();
        finish_test();
    end
endmodule // gpio_ports_with_wake_events_bench
